/* File: core/scfg_pkg.sv */
/*
  Constants and types for the strap latch and two-wire configuration block.
  Assumes a 100 MHz system clock and an open-drain two-wire bus with pull-ups.
*/
// Notes on behaviour
// - capture strap levels at reset release
// - fixed-port strap sets fixed ports, indicator polarity
// - local power takes fixed ports from register
// - high charge strap enables port charging
// - port disabled only when both straps high
// - standard mode 100 kbit/s, 7-bit addresses
// - as memory host, device makes clock, start, stop
// - base protocol only, no extensions
// - host side serves one configuration memory
// - first byte after address sets pointer
// - write data stored, acknowledged, pointer incremented
// - stop condition ends sequential write
// - read returns pointer byte, then increments
// - select straps and data line choose method
package scfg_pkg;
  localparam int unsigned CLK_NS    = 10;
  localparam int unsigned BUS_KBPS  = 100;
  localparam int unsigned QTR_NS    = 1000000 / BUS_KBPS / 4;
  localparam int unsigned QTR_CYC   = QTR_NS / CLK_NS;
  localparam logic [8:0]  QTR_CNT   = 9'(QTR_CYC - 1);
  localparam logic [1:0]  LATCH_DLY = 2'h3;
  // bus addresses: arbitrary defaults
  localparam logic [6:0]  DEV_ADDR  = 7'h2d;
  localparam logic [6:0]  MEM_ADDR  = 7'h50;
  localparam logic [7:0]  LOAD_LEN  = 8'h10;
  localparam logic [7:0]  REG_FIXED_PORT = 8'h00;
  localparam int unsigned REG_DEPTH = 256;
  localparam int unsigned FIFO_W    = 16;
  localparam int unsigned FIFO_D    = 16;
  localparam int unsigned FIX_LSB   = 0;
  localparam int unsigned CHG_LSB   = 2;
  localparam int unsigned MIN_LSB   = 6;
  localparam int unsigned PLS_LSB   = 10;
  localparam int unsigned SEL_LSB   = 14;
  localparam int unsigned STRAP_W   = 16;

  typedef enum logic [2:0] {SCFG_SELF, SCFG_BUS, SCFG_MEM, SCFG_HOSTWAIT, SCFG_INVALID} scfg_mode_t;
  typedef enum logic [2:0] {T_IDLE, T_ADDR, T_REG, T_WR, T_RD, T_SKIP} scfg_tst_t;
  typedef enum logic [2:0] {H_IDLE, H_START, H_BYTE, H_STOP, H_DONE} scfg_hst_t;
endpackage

/* File: core/scfg_core.sv */
/*
  Strap latch, two-wire register target, configuration memory loader,
  write FIFO and register file.
  Assumes pins arrive asynchronous to mclk and a testbench resolves the
  open-drain wires from the drive enables.
*/
`timescale 1ns/1ps

module scfg_fifo #(
  parameter int unsigned W = 16,
  parameter int unsigned D = 16
) (
  input  wire logic         mclk,
  input  wire logic         rstn,
  input  wire logic         in_valid,
  output logic              in_ready,
  input  wire logic [W-1:0] in_data,
  output logic              out_valid,
  input  wire logic         out_ready,
  output logic [W-1:0]      out_data
);
  localparam int unsigned AW = $clog2(D);
  typedef struct packed {
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [AW:0]   cnt;
  } scfg_fifo_st_t;
  scfg_fifo_st_t q, d;
  logic [W-1:0]  mem [D];
  logic          wr;
  logic          rd;

  assign in_ready  = q.cnt != (AW+1)'(D);
  assign out_valid = q.cnt != '0;
  assign out_data  = mem[q.rp];
  assign wr        = in_valid && in_ready;
  assign rd        = out_valid && out_ready;

  always_comb begin
    d = q;
    if (wr) d.wp = q.wp + AW'(1);
    if (rd) d.rp = q.rp + AW'(1);
    d.cnt = q.cnt + (AW+1)'(wr) - (AW+1)'(rd);
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) q <= '0;
    else q <= d;
  end

  always_ff @(posedge mclk) begin
    if (wr) mem[q.wp] <= in_data;
  end
endmodule

////////////////////////////////////////////////////////////////////////////////

module scfg_core (
  input  wire logic        mclk,
  input  wire logic        rstn,
  input  wire logic [1:0]  fixed_port_strap,
  input  wire logic [3:0]  port_charge_enable_strap,
  input  wire logic [3:0]  port_minus_line_disable_strap,
  input  wire logic [3:0]  port_plus_line_disable_strap,
  input  wire logic [1:0]  cfg_sel_strap,
  output logic [15:0]      strap_drive,
  output logic             strap_drive_en,
  input  wire logic        local_power_detect,
  input  wire logic        suspend_request,
  input  wire logic        reg_hold,
  input  wire logic        scl_in,
  output logic             scl_out,
  output logic             scl_drive_en,
  input  wire logic        sda_in,
  output logic             sda_out,
  output logic             sda_drive_en,
  output logic [2:0]       fixed_port_mask,
  output logic             suspend_indicator,
  output logic [3:0]       port_charge_enable,
  output logic [3:0]       port_disable,
  output scfg_pkg::scfg_mode_t cfg_mode,
  output logic             straps_latched,
  output logic             config_loaded
);
  typedef struct packed {
    logic [15:0]           strap_s1;
    logic [15:0]           strap_s2;
    logic [2:0]            pin_s1;
    logic [2:0]            pin_s2;
    logic                  scl_h;
    logic                  sda_h;
    logic [1:0]            dly;
    logic                  latched;
    logic [15:0]           cap;
    logic                  sda_cap;
    scfg_pkg::scfg_mode_t  mode;
    logic [2:0]            fixed;
    logic                  susp;
    logic [3:0]            chg;
    logic [3:0]            dis;
    logic [15:0]           sdrv;
    scfg_pkg::scfg_tst_t   tst;
    logic                  ackph;
    logic [3:0]            bitcnt;
    logic [7:0]            sh;
    logic [7:0]            tx;
    logic [7:0]            ptr;
    logic                  rd_ld;
    logic                  t_oe;
    scfg_pkg::scfg_hst_t   hst;
    logic [1:0]            hq;
    logic [8:0]            hdiv;
    logic [3:0]            hbit;
    logic [7:0]            hbyte;
    logic [7:0]            hsh;
    logic [7:0]            hptr;
    logic                  h_sda;
    logic                  h_scl;
    logic                  sda_oe;
    logic                  scl_oe;
    logic                  pin_lo;
    logic                  done;
    logic                  push_v;
    logic [7:0]            push_a;
    logic [7:0]            push_b;
  } scfg_st_t;

  scfg_st_t     q, d;
  logic [7:0]   regs [scfg_pkg::REG_DEPTH];
  logic         fifo_rdy;
  logic         f_valid;
  logic [15:0]  f_data;
  logic         scl, sda, lp;
  logic         t_rise, t_fall, t_start, t_stop;
  logic         h_busy, t_en, h_tick;
  logic [7:0]   rd_byte;
  logic [2:0]   reg_nonrem;

  function automatic logic [2:0] fixed_f(input logic [1:0] s);
    unique case (s)
      2'h0: fixed_f = 3'h0;
      2'h1: fixed_f = 3'h1;
      2'h2: fixed_f = 3'h3;
      2'h3: fixed_f = 3'h7;
    endcase
  endfunction

  function automatic scfg_pkg::scfg_mode_t mode_f(input logic [1:0] s, input logic dl);
    unique case (s)
      2'h0: mode_f = scfg_pkg::SCFG_SELF;
      2'h2: mode_f = scfg_pkg::SCFG_BUS;
      2'h3: mode_f = dl ? scfg_pkg::SCFG_MEM : scfg_pkg::SCFG_INVALID;
      2'h1: mode_f = dl ? scfg_pkg::SCFG_HOSTWAIT : scfg_pkg::SCFG_INVALID;
    endcase
  endfunction

  scfg_fifo #(.W(scfg_pkg::FIFO_W), .D(scfg_pkg::FIFO_D)) u_scfg_fifo (
    .mclk      (mclk),
    .rstn      (rstn),
    .in_valid  (q.push_v),
    .in_ready  (fifo_rdy),
    .in_data   ({q.push_a, q.push_b}),
    .out_valid (f_valid),
    .out_ready (!reg_hold),
    .out_data  (f_data)
  );

  // reg_hold stalls the drain so writes queue and the bus sees NACKs when full
  always_ff @(posedge mclk) begin
    if (f_valid && !reg_hold) regs[f_data[15:8]] <= f_data[7:0];
  end

  assign scl        = q.pin_s2[1];
  assign sda        = q.pin_s2[0];
  assign lp         = q.pin_s2[2];
  assign t_rise     = scl && !q.scl_h;
  assign t_fall     = !scl && q.scl_h;
  assign t_start    = scl && q.scl_h && q.sda_h && !sda;
  assign t_stop     = scl && q.scl_h && !q.sda_h && sda;
  assign h_busy     = q.hst inside {scfg_pkg::H_START, scfg_pkg::H_BYTE, scfg_pkg::H_STOP};
  assign t_en       = q.latched && !h_busy;
  assign h_tick     = q.hdiv == scfg_pkg::QTR_CNT;
  assign rd_byte    = regs[q.ptr];
  assign reg_nonrem = regs[scfg_pkg::REG_FIXED_PORT][2:0];

  ////////////////////////////////////////////////////////////////////////////////
  always_comb begin
    d          = q;
    d.strap_s1 = {cfg_sel_strap, port_plus_line_disable_strap, port_minus_line_disable_strap,
                  port_charge_enable_strap, fixed_port_strap};
    d.strap_s2 = q.strap_s1;
    d.pin_s1   = {local_power_detect, scl_in, sda_in};
    d.pin_s2   = q.pin_s1;
    d.scl_h    = scl;
    d.sda_h    = sda;
    d.rd_ld    = 1'b0;
    d.pin_lo   = 1'b0;
    if (q.push_v && fifo_rdy) d.push_v = 1'b0;

    // one capture only; sync chain refills after release before the sample
    if (!q.latched) begin
      if (q.dly == scfg_pkg::LATCH_DLY) begin
        d.latched = 1'b1;
        d.cap     = q.strap_s2;
        d.sda_cap = sda;
      end else begin
        d.dly = q.dly + 2'h1;
      end
    end else begin
      d.mode  = mode_f(q.cap[scfg_pkg::SEL_LSB +: 2], q.sda_cap);
      d.fixed = lp ? reg_nonrem : fixed_f(q.cap[scfg_pkg::FIX_LSB +: 2]);
      d.susp  = suspend_request ^ q.cap[scfg_pkg::FIX_LSB];
      d.chg   = q.cap[scfg_pkg::CHG_LSB +: 4];
      d.dis   = q.cap[scfg_pkg::MIN_LSB +: 4] & q.cap[scfg_pkg::PLS_LSB +: 4];
      d.sdrv  = q.cap;
      d.sdrv[scfg_pkg::FIX_LSB] = d.susp;
    end

    // target side: 7-bit address, pointer byte, auto-increment
    if (!t_en || t_stop) begin
      d.tst   = scfg_pkg::T_IDLE;
      d.t_oe  = 1'b0;
      d.ackph = 1'b0;
    end else if (t_start) begin
      d.tst    = scfg_pkg::T_ADDR;
      d.bitcnt = 4'h0;
      d.ackph  = 1'b0;
      d.t_oe   = 1'b0;
    end else if (t_rise && q.tst != scfg_pkg::T_IDLE) begin
      if (q.ackph) begin
        if (q.tst == scfg_pkg::T_RD && sda) d.tst = scfg_pkg::T_SKIP;
      end else begin
        if (q.tst != scfg_pkg::T_RD) d.sh = {q.sh[6:0], sda};
        d.bitcnt = q.bitcnt + 4'h1;
      end
    end else if (t_fall && q.tst != scfg_pkg::T_IDLE && q.tst != scfg_pkg::T_SKIP) begin
      if (q.ackph) begin
        d.ackph = 1'b0;
        d.t_oe  = 1'b0;
        if (q.tst == scfg_pkg::T_RD) begin
          d.tx    = {rd_byte[6:0], 1'b0};
          d.t_oe  = !rd_byte[7];
          d.ptr   = q.ptr + 8'h1;
          d.rd_ld = 1'b1;
        end
      end else if (q.bitcnt == 4'h8) begin
        d.ackph  = 1'b1;
        d.bitcnt = 4'h0;
        d.t_oe   = 1'b0;
        unique case (q.tst)
          scfg_pkg::T_ADDR: begin
            if (q.sh[7:1] == scfg_pkg::DEV_ADDR) begin
              d.t_oe = 1'b1;
              d.tst  = q.sh[0] ? scfg_pkg::T_RD : scfg_pkg::T_REG;
            end else begin
              d.tst = scfg_pkg::T_SKIP;
            end
          end
          scfg_pkg::T_REG: begin
            d.ptr  = q.sh;
            d.t_oe = 1'b1;
            d.tst  = scfg_pkg::T_WR;
          end
          scfg_pkg::T_WR: begin
            // a full queue answers NACK: the write is dropped, not stalled
            if (!q.push_v && fifo_rdy) begin
              d.push_v = 1'b1;
              d.push_a = q.ptr;
              d.push_b = q.sh;
              d.ptr    = q.ptr + 8'h1;
              d.t_oe   = 1'b1;
            end
          end
          default: ;
        endcase
      end else if (q.tst == scfg_pkg::T_RD) begin
        d.t_oe = !q.tx[7];
        d.tx   = {q.tx[6:0], 1'b0};
      end
    end

    // host side: one memory read burst into the register file
    d.hdiv = (h_busy && !h_tick) ? q.hdiv + 9'h1 : 9'h0;
    unique case (q.hst)
      scfg_pkg::H_IDLE: begin
        if (q.latched && q.mode == scfg_pkg::SCFG_MEM) d.hst = scfg_pkg::H_START;
      end
      scfg_pkg::H_START: begin
        if (h_tick) begin
          d.hq = q.hq + 2'h1;
          unique case (q.hq)
            2'h0: d.h_sda = 1'b0;
            2'h1: d.h_sda = 1'b1;
            2'h2: d.h_scl = 1'b1;
            2'h3: begin
              d.hst   = scfg_pkg::H_BYTE;
              d.hbit  = 4'h0;
              d.hbyte = 8'h0;
              d.hsh   = {scfg_pkg::MEM_ADDR, 1'b1};
            end
          endcase
        end
      end
      scfg_pkg::H_BYTE: begin
        if (h_tick) begin
          d.hq = q.hq + 2'h1;
          unique case (q.hq)
            2'h0: begin
              d.h_scl = 1'b1;
              if (q.hbit != 4'h8) d.h_sda = (q.hbyte == 8'h0) && !q.hsh[7];
              else d.h_sda = (q.hbyte != 8'h0) && (q.hbyte != scfg_pkg::LOAD_LEN);
            end
            2'h1: d.h_scl = 1'b0;
            2'h2: begin
              if (q.hbit != 4'h8) d.hsh = {q.hsh[6:0], sda};
              else if (q.hbyte == 8'h0 && sda) d.hbyte = scfg_pkg::LOAD_LEN;
            end
            2'h3: begin
              d.h_scl = 1'b1;
              if (q.hbit == 4'h7 && q.hbyte != 8'h0) begin
                // back-pressure: hold SCL low until the queue takes the byte
                if (q.push_v || !fifo_rdy) begin
                  d.hq   = q.hq;
                  d.hdiv = q.hdiv;
                end else begin
                  d.push_v = 1'b1;
                  d.push_a = q.hptr;
                  d.push_b = q.hsh;
                  d.hptr   = q.hptr + 8'h1;
                end
              end
              if (d.hq != q.hq) begin
                if (q.hbit != 4'h8) begin
                  d.hbit = q.hbit + 4'h1;
                end else begin
                  d.hbit = 4'h0;
                  if (q.hbyte == scfg_pkg::LOAD_LEN) d.hst = scfg_pkg::H_STOP;
                  else d.hbyte = q.hbyte + 8'h1;
                end
              end
            end
          endcase
        end
      end
      scfg_pkg::H_STOP: begin
        if (h_tick) begin
          d.hq = q.hq + 2'h1;
          unique case (q.hq)
            2'h0: d.h_sda = 1'b1;
            2'h1: d.h_scl = 1'b0;
            2'h2: d.h_sda = 1'b0;
            2'h3: begin
              d.hst  = scfg_pkg::H_DONE;
              d.done = 1'b1;
            end
          endcase
        end
      end
      scfg_pkg::H_DONE: ;
    endcase

    d.scl_oe = (d.hst inside {scfg_pkg::H_START, scfg_pkg::H_BYTE, scfg_pkg::H_STOP}) && d.h_scl;
    d.sda_oe = (d.hst inside {scfg_pkg::H_START, scfg_pkg::H_BYTE, scfg_pkg::H_STOP}) ? d.h_sda
                                                                                       : d.t_oe;
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      q      <= '0;
      q.mode <= scfg_pkg::SCFG_SELF;
      q.tst  <= scfg_pkg::T_IDLE;
      q.hst  <= scfg_pkg::H_IDLE;
    end else begin
      q <= d;
    end
  end

  assign strap_drive        = q.sdrv;
  assign strap_drive_en     = q.latched;
  assign scl_out            = q.pin_lo;
  assign scl_drive_en       = q.scl_oe;
  assign sda_out            = q.pin_lo;
  assign sda_drive_en       = q.sda_oe;
  assign fixed_port_mask    = q.fixed;
  assign suspend_indicator  = q.susp;
  assign port_charge_enable = q.chg;
  assign port_disable       = q.dis;
  assign cfg_mode           = q.mode;
  assign straps_latched     = q.latched;
  assign config_loaded      = q.done;

  ////////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rstn);

  a_pins_float_reset: assert property (!straps_latched |-> !strap_drive_en && !sda_drive_en)
    else $error("pins driven before strap capture");
  a_latch_value: assert property ($rose(q.latched) |-> q.cap == $past(q.strap_s2))
    else $error("strap capture differs from synchronised pins");
  a_latch_hold: assert property (straps_latched |=> straps_latched && $stable(q.cap))
    else $error("captured straps changed");
  a_fixed_decode: assert property (q.latched && !lp |=> fixed_port_mask == fixed_f(q.cap[1:0]))
    else $error("fixed port decode wrong");
  a_susp_polarity: assert property (q.latched |=>
                                    suspend_indicator == ($past(suspend_request) ^ q.cap[0]))
    else $error("suspend indicator polarity wrong");
  a_local_power: assert property (q.latched && lp |=> fixed_port_mask == $past(reg_nonrem))
    else $error("local power did not select register");
  a_charge_enable: assert property (straps_latched |=> port_charge_enable == q.cap[5:2])
    else $error("charge enable mismatch");
  a_port_disable: assert property (straps_latched |=> port_disable == (q.cap[9:6] & q.cap[13:10]))
    else $error("port disable mismatch");
  a_mode_select: assert property (straps_latched |=> cfg_mode == mode_f(q.cap[15:14], q.sda_cap))
    else $error("configuration method wrong");
  a_scl_quarter: assert property ($changed(scl_drive_en) |-> $past(q.hdiv) == scfg_pkg::QTR_CNT)
    else $error("clock edge off the quarter-bit tick");
  a_host_mem_only: assert property (scl_drive_en |-> cfg_mode == scfg_pkg::SCFG_MEM)
    else $error("clock driven outside memory mode");
  a_reg_pointer: assert property ($rose(q.ackph) && $past(q.tst) == scfg_pkg::T_REG
                                  |-> q.ptr == $past(q.sh))
    else $error("pointer not set from register byte");
  a_write_store: assert property ($rose(q.push_v) && q.tst == scfg_pkg::T_WR
                                  |-> sda_drive_en && q.ackph ##1 q.ptr == q.push_a + 8'h1)
    else $error("write byte not stored and acknowledged");
  a_stop_idle: assert property (t_stop && t_en |=> q.tst == scfg_pkg::T_IDLE)
    else $error("stop did not end transfer");
  a_read_incr: assert property (q.rd_ld |-> q.ptr == $past(q.ptr) + 8'h1)
    else $error("read pointer not incremented");

  c_write_byte: cover property ($rose(q.push_v) && q.tst == scfg_pkg::T_WR);
  c_read_nack: cover property (q.tst == scfg_pkg::T_RD ##1 q.tst == scfg_pkg::T_SKIP);
  c_load_done: cover property ($rose(config_loaded));
endmodule

/* File: tb/scfg_bus_host.sv */
/*
  Two-wire bus host model that drives register accesses into the block.
  Assumes the bench resolves both open-drain wires with pull-ups.
*/
`timescale 1ns/1ps

module scfg_bus_host (
  input  wire logic scl,
  input  wire logic sda,
  output logic      scl_low,
  output logic      sda_low
);
  // quarter of the 80 ns bit; scl stands still between calls
  localparam int Q = 20;

  initial begin
    scl_low = 1'b0;
    sda_low = 1'b0;
  end

  // sda falls while scl high; also serves as repeated start
  task automatic go_start();
    #Q sda_low = 1'b0;
    #Q scl_low = 1'b0;
    #Q sda_low = 1'b1;
    #Q scl_low = 1'b1;
  endtask

  task automatic go_stop();
    #Q sda_low = 1'b1;
    #Q scl_low = 1'b0;
    #(2*Q) sda_low = 1'b0;
    #(2*Q);
  endtask

  // data moves only while scl low, read back late in scl high
  task automatic bit_io(input logic b, output logic v);
    #Q sda_low = ~b;
    #Q scl_low = 1'b0;
    #(2*Q-1) v = sda;
    #1 scl_low = 1'b1;
  endtask

  // msb first; nak is the ack slot level, 1 = refused
  task automatic put_byte(input logic [7:0] b, output logic nak);
    logic v;
    for (int i = 7; i >= 0; i--) begin
      bit_io(b[i], v);
    end
    bit_io(1'b1, nak);
  endtask

  // final byte of a read is answered with not-acknowledge
  task automatic get_byte(input logic last, output logic [7:0] b);
    logic v;
    for (int i = 7; i >= 0; i--) begin
      bit_io(1'b1, b[i]);
    end
    bit_io(last, v);
  endtask
endmodule

/* File: tb/test_strap_latch_i2c_config_access.sv */
/*
  Self-checking bench: strap capture and decode, register writes and reads
  over the two-wire bus, fifo back-pressure.
  Assumes scfg_core and the scfg_bus_host model.
*/
`timescale 1ns/1ps

module test_strap_latch_i2c_config_access;
  logic        mclk;
  logic        rstn;
  logic [1:0]  fix_s;
  logic [3:0]  chg_s;
  logic [3:0]  min_s;
  logic [3:0]  pls_s;
  logic [1:0]  sel_s;
  logic        lpd;
  logic        susp_req;
  logic        hold;
  logic        sda_pd;
  logic        h_scl_low;
  logic        h_sda_low;
  wire         scl_w;
  wire         sda_w;
  logic        scl_en;
  logic        sda_en;
  logic        scl_o;
  logic        sda_o;
  logic        loaded;
  logic [15:0] drv;
  logic        drv_en;
  logic [2:0]  fpm;
  logic        susp;
  logic [3:0]  chg;
  logic [3:0]  dis;
  logic        latched;
  logic        nak;
  logic [7:0]  rd;
  int          n_errors = 0;
  int          checks = 0;
  int          cycles = 0;
  scfg_pkg::scfg_mode_t mode;
  logic [1:0]  sels [4] = '{2'h0, 2'h2, 2'h1, 2'h1};
  scfg_pkg::scfg_mode_t modes [4] = '{scfg_pkg::SCFG_SELF, scfg_pkg::SCFG_BUS,
                                      scfg_pkg::SCFG_HOSTWAIT, scfg_pkg::SCFG_INVALID};

  // pull-ups win unless some party pulls low
  assign scl_w = (scl_en ? scl_o : 1'b1) & ~h_scl_low;
  assign sda_w = (sda_en ? sda_o : 1'b1) & ~(h_sda_low | sda_pd);

  scfg_core u_scfg_core (
    .mclk                          (mclk),
    .rstn                          (rstn),
    .fixed_port_strap              (fix_s),
    .port_charge_enable_strap      (chg_s),
    .port_minus_line_disable_strap (min_s),
    .port_plus_line_disable_strap  (pls_s),
    .cfg_sel_strap                 (sel_s),
    .strap_drive                   (drv),
    .strap_drive_en                (drv_en),
    .local_power_detect            (lpd),
    .suspend_request               (susp_req),
    .reg_hold                      (hold),
    .scl_in                        (scl_w),
    .scl_out                       (scl_o),
    .scl_drive_en                  (scl_en),
    .sda_in                        (sda_w),
    .sda_out                       (sda_o),
    .sda_drive_en                  (sda_en),
    .fixed_port_mask               (fpm),
    .suspend_indicator             (susp),
    .port_charge_enable            (chg),
    .port_disable                  (dis),
    .cfg_mode                      (mode),
    .straps_latched                (latched),
    .config_loaded                 (loaded)
  );

  scfg_bus_host u_host (
    .scl     (scl_w),
    .sda     (sda_w),
    .scl_low (h_scl_low),
    .sda_low (h_sda_low)
  );

////////////////////////////////////////////////////////////////////////////////

  task automatic complete_run();
    $display("checks %0d n_errors %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("unexpected %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic do_reset();
    rstn = 1'b0;
    repeat (8) @(negedge mclk);
    check("pins released", {15'h0, drv_en}, 16'h0);
    rstn = 1'b1;
    repeat (12) @(negedge mclk);
  endtask

  task automatic chk_straps(input int i);
    logic [1:0] f;
    logic [3:0] c;
    f = 2'(i);
    c = 4'h1 << i;
    check("latched", {14'h0, latched, drv_en}, 16'h3);
    check("fixed mask", {13'h0, fpm}, {13'h0, f[1] & f[0], f[1], f[1] | f[0]});
    check("suspend", {15'h0, susp}, {15'h0, f[0]});
    check("charge", {12'h0, chg}, {12'h0, c});
    check("disable", {12'h0, dis}, 16'h0008);
    check("mode", {13'h0, mode}, {13'h0, modes[i]});
    check("strap drive", drv, {sels[i], 4'ha, 4'hc, c, f[1], f[0]});
  endtask

  task automatic wr(input logic [7:0] b, input logic exp_nak);
    u_host.put_byte(b, nak);
    check("ack slot", {15'h0, nak}, {15'h0, exp_nak});
  endtask

  task automatic rdb(input logic last, input logic [7:0] exp);
    u_host.get_byte(last, rd);
    check("read byte", {8'h0, rd}, {8'h0, exp});
  endtask

  task automatic set_ptr(input logic [7:0] r);
    u_host.go_start();
    wr({scfg_pkg::DEV_ADDR, 1'b0}, 1'b0);
    wr(r, 1'b0);
  endtask

  task automatic open_rd();
    u_host.go_start();
    wr({scfg_pkg::DEV_ADDR, 1'b1}, 1'b0);
  endtask

////////////////////////////////////////////////////////////////////////////////

  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  // generous ceiling: the run needs about 16000 cycles, most of it the memory load
  always @(posedge mclk) begin
    cycles <= cycles + 1;
    if (cycles == 30000) begin
      n_errors++;
      complete_run();
    end
  end

  initial begin
    {rstn, fix_s, chg_s, min_s, pls_s, sel_s, lpd, susp_req, hold, sda_pd} = '0;
    @(negedge mclk);
    for (int i = 0; i < 4; i++) begin
      fix_s = 2'(i);
      chg_s = 4'h1 << i;
      min_s = 4'hc;
      pls_s = 4'ha;
      sel_s = sels[i];
      sda_pd = (i == 3);
      susp_req = 1'b0;
      do_reset();
      sda_pd = 1'b0;
      chk_straps(i);
      fix_s = ~fix_s;
      chg_s = ~chg_s;
      pls_s = 4'hf;
      sel_s = ~sel_s;
      repeat (8) @(negedge mclk);
      chk_straps(i);
      susp_req = 1'b1;
      repeat (4) @(negedge mclk);
      check("suspend on", {15'h0, susp}, {15'h0, ~i[0]});
    end
    {fix_s, chg_s, min_s, pls_s, sel_s, susp_req} = '0;
    do_reset();
    u_host.go_start();
    wr({scfg_pkg::DEV_ADDR ^ 7'h01, 1'b0}, 1'b1);
    u_host.go_stop();
    // pointer wraps from 0xff to 0x00
    set_ptr(8'hfe);
    wr(8'h11, 1'b0);
    wr(8'h22, 1'b0);
    wr(8'h33, 1'b0);
    u_host.go_stop();
    set_ptr(8'hfe);
    open_rd();
    rdb(1'b0, 8'h11);
    rdb(1'b0, 8'h22);
    rdb(1'b1, 8'h33);
    u_host.go_stop();
    @(negedge mclk);
    lpd = 1'b1;
    repeat (10) @(negedge mclk);
    check("local fixed", {13'h0, fpm}, 16'h0003);
    set_ptr(8'hff);
    u_host.go_stop();
    open_rd();
    rdb(1'b1, 8'h22);
    u_host.go_stop();
    open_rd();
    rdb(1'b1, 8'h33);
    u_host.go_stop();
    // drain stalled: sixteen words fit, the next is refused
    @(negedge mclk);
    hold = 1'b1;
    set_ptr(8'h10);
    for (int k = 0; k < 17; k++) begin
      wr(8'h40 + 8'(k), k == 16);
    end
    u_host.go_stop();
    @(negedge mclk);
    hold = 1'b0;
    repeat (40) @(negedge mclk);
    set_ptr(8'h10);
    open_rd();
    for (int k = 0; k < 16; k++) begin
      rdb(k == 15, 8'h40 + 8'(k));
    end
    u_host.go_stop();
    // memory mode: nothing answers the loader, so it stops after the address byte
    sel_s = 2'h3;
    do_reset();
    check("mode mem", {13'h0, mode}, {13'h0, scfg_pkg::SCFG_MEM});
    repeat (620) @(negedge mclk);
    check("load start", {13'h0, loaded, scl_en, sda_en}, 16'h0001);
    repeat (380) @(negedge mclk);
    check("load clock", {13'h0, loaded, scl_en, sda_en}, 16'h0003);
    repeat (10320) @(negedge mclk);
    check("load end", {13'h0, loaded, scl_en, sda_en}, 16'h0004);
    complete_run();
  end
endmodule
